// ===== core/evp_core.v
// exception entry: reset, traps, pin and peripheral requests to a vector
// assumes a cpu sequencer that flags instruction and exception completion,
// and peripherals that hold their request level until software clears it
// What this block does
// RULE_01 - reset outranks everything, uses vector 0, starts at pin release
// RULE_02 - watchdog overflow resets the chip exactly like the pin
// RULE_03 - software vector call picks vector 8 to 11 from its field
// RULE_04 - software vector call is taken regardless of the mask bit
// RULE_05 - mask bit set holds off all but reset, nmi, trap, break
// RULE_06 - entry only after current instruction or exception processing ends
// RULE_07 - several pending requests: lowest vector number served first
// RULE_08 - vector address is twice the number; fixed source numbering
// RULE_09 - low-power direct transition raises vector 13
// RULE_10 - pin request 0 on vector 14, shared with optional low-voltage
// RULE_11 - 8-bit timer compare A, B and overflow share vector 22
// RULE_12 - primary serial shares vector 23, second serial vector 32
// RULE_13 - two-wire unit's six requests share vector 24
// RULE_14 - multi timer ch0 on 26, ch1 on 27, adc 25, plain timer 29
// RULE_15 - pins detect falling edge on select 0, rising on 1; reset 0
// RULE_16 - six wake pins share one enable onto the wake vector
// RULE_17 - handlers read peripheral flags to tell shared sources apart
`timescale 1ns/10ps
`include "evp_regs.vh"

module evp_core #(
  parameter LOW_VOLT_PRESENT = 0
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // chip clear pin, active low, asynchronous
  input wire chipClearPinN,
  input wire watchdogOverflow,
  // cpu sequencer
  input wire instrDone,
  input wire excDone,
  input wire programState,
  input wire maskBit,
  input wire softwareVectorCall,
  input wire [1:0] softwareVectorField,
  input wire addrBreakHit,
  input wire sleepDirect,
  input wire sleepDirectEnable,
  // external pins: nmi, edge requests 0..3, wake group 0..5
  input wire [`EVP_PIN_COUNT-1:0] pinRaw,
  input wire [`EVP_PIN_COUNT-1:0] pinEdgeSel,
  input wire [3:0] edgePinEnable,
  input wire wakeEnable,
  // peripheral request levels
  input wire lowVoltReq,
  input wire clockOverflowReq,
  input wire [2:0] timer8Req,
  input wire [3:0] serialPrimaryReq,
  input wire [5:0] twoWireReq,
  input wire adcEndReq,
  input wire [4:0] multiTimer0Req,
  input wire [5:0] multiTimer1Req,
  input wire plainTimerOvfReq,
  input wire [3:0] serialSecondReq,
  // to the cpu
  output reg coreReset,
  output reg excReq,
  output reg [`EVP_VEC_W-1:0] excVector,
  output reg [`EVP_ADDR_W-1:0] excAddr,
  output reg excInService
);

  wire clearLevel;
  wire [`EVP_PIN_COUNT-1:0] pinEdge;
  wire [`EVP_PIN_COUNT-1:0] pinEnable;
  wire [`EVP_PIN_COUNT-1:0] pinClr;
  wire [`EVP_VEC_COUNT-1:0] rawReq;
  wire [`EVP_VEC_COUNT-1:0] liveReq;
  wire anyReq;
  wire [`EVP_VEC_W-1:0] winVec;
  wire boundary;
  wire takeNow;
  wire resetRise;
  wire lowVoltShared;
  reg [`EVP_PIN_COUNT-1:0] pinPend;
  reg [`EVP_TRAP_COUNT-1:0] trapPend;
  reg breakPend;
  reg sleepPend;
  reg resetPend;
  reg next_coreReset;

  // chip clear pin through the same filtered synchroniser, no edge needed
  // limitation: a pin already low when srst ends gives a short release,
  // since the stages restart at the idle level
  evp_pin_sync clearSync (
    .clk(clk),
    .srst(srst),
    .pinRaw(chipClearPinN),
    .edgeSel(`EVP_EDGE_RISE),
    .pinLevel(clearLevel),
    .pinEdge()
  );

  // RULE_15 - per-pin edge detect
  genvar p;
  generate
    for (p = 0; p < `EVP_PIN_COUNT; p = p + 1) begin : gPin
      // vector that this pin's latch feeds; all wake pins land on one number
      localparam integer VEC = (p == `EVP_PIN_NMI) ? `EVP_VEC_NMI :
        (p < `EVP_PIN_WAKE0) ? (`EVP_VEC_PIN0 + p - `EVP_PIN_EDGE_PIN_REQUEST_0) : `EVP_VEC_WAKE;
      evp_pin_sync pinSync (
        .clk(clk),
        .srst(srst),
        .pinRaw(pinRaw[p]),
        .edgeSel(pinEdgeSel[p]),
        .pinLevel(),
        .pinEdge(pinEdge[p])
      );
      // RULE_16 - wake pins common enable
      if (p == `EVP_PIN_NMI) begin : gNmi
        assign pinEnable[p] = `EVP_ONE_BIT;
      end else if (p < `EVP_PIN_WAKE0) begin : gIrq
        assign pinEnable[p] = edgePinEnable[p-`EVP_PIN_EDGE_PIN_REQUEST_0];
      end else begin : gWake
        assign pinEnable[p] = wakeEnable;
      end
      // a latched edge is dropped once its vector is entered
      assign pinClr[p] = takeNow && (winVec == VEC[`EVP_VEC_W-1:0]);
      // an edge in the very cycle of the clear still lands
      // the latch is dropped on any core reset, so edges seen then are lost
      always @(posedge clk) begin
        if (srst || coreReset) begin
          pinPend[p] <= `EVP_ZERO_BIT;
        end else if (pinEdge[p]) begin
          pinPend[p] <= `EVP_ONE_BIT;
        end else if (pinClr[p]) begin
          pinPend[p] <= `EVP_ZERO_BIT;
        end
      end
    end
  endgenerate

  // RULE_01 - reset hold and release
  // RULE_02 - watchdog same path
  // holding the core while the pin is low; one cycle for a watchdog pulse
  always @* begin
    next_coreReset = srst || watchdogOverflow || (clearLevel == `EVP_ZERO_BIT);
  end

  assign resetRise = coreReset && !next_coreReset;

  // registered so the core sees a clean level; srst is folded into the next value
  always @(posedge clk) begin
    coreReset <= next_coreReset;
  end

  // reset vector is pending from the release until it is presented
  // it needs no boundary, so it is taken the cycle after coreReset falls
  always @(posedge clk) begin
    if (srst || next_coreReset) begin
      resetPend <= `EVP_ZERO_BIT;
    end else if (resetRise) begin
      resetPend <= `EVP_ONE_BIT;
    end else if (takeNow && (winVec == `EVP_VEC_RESET)) begin
      resetPend <= `EVP_ZERO_BIT;
    end
  end

  // RULE_03 - trap field to one-hot
  // RULE_04 - trap ignores mask bit
  // a call outside the program state is dropped, never held for later
  always @(posedge clk) begin
    if (srst || coreReset) begin
      trapPend <= {`EVP_TRAP_COUNT{`EVP_ZERO_BIT}};
    end else begin
      trapPend <= (trapPend & ~liveClrTrap(takeNow, winVec)) |
        ((softwareVectorCall && programState) ? onehotTrap(softwareVectorField) :
        {`EVP_TRAP_COUNT{`EVP_ZERO_BIT}});
    end
  end

  // one-hot of the two-bit trap field
  function [`EVP_TRAP_COUNT-1:0] onehotTrap;
    input [1:0] field;
    begin
      onehotTrap = {{(`EVP_TRAP_COUNT-1){`EVP_ZERO_BIT}}, `EVP_ONE_BIT} << field;
    end
  endfunction

  // which trap bit the current entry retires
  function [`EVP_TRAP_COUNT-1:0] liveClrTrap;
    input take;
    input [`EVP_VEC_W-1:0] vec;
    integer t;
    begin
      liveClrTrap = {`EVP_TRAP_COUNT{`EVP_ZERO_BIT}};
      for (t = 0; t < `EVP_TRAP_COUNT; t = t + 1) begin
        if (take && (vec == (`EVP_VEC_TRAP0 + t))) begin
          liveClrTrap[t] = `EVP_ONE_BIT;
        end
      end
    end
  endfunction

  // RULE_09 - direct transition latch
  // break and sleep arrive as pulses; set wins over the entry clear
  // a sleep latch left while disabled fires once the enable comes up
  always @(posedge clk) begin
    if (srst || coreReset) begin
      breakPend <= `EVP_ZERO_BIT;
      sleepPend <= `EVP_ZERO_BIT;
    end else begin
      if (addrBreakHit) begin
        breakPend <= `EVP_ONE_BIT;
      end else if (takeNow && (winVec == `EVP_VEC_BREAK)) begin
        breakPend <= `EVP_ZERO_BIT;
      end
      if (sleepDirect) begin
        sleepPend <= `EVP_ONE_BIT;
      end else if (takeNow && (winVec == `EVP_VEC_SLEEP)) begin
        sleepPend <= `EVP_ZERO_BIT;
      end
    end
  end

  // RULE_10 - low-voltage shares vector 14
  // absent variants tie it off so a floating input cannot fire
  assign lowVoltShared = (LOW_VOLT_PRESENT != 0) ? lowVoltReq : `EVP_ZERO_BIT;

  // RULE_08 - source to vector map
  // reserved numbers stay zero; shared vectors are or-ed
  // RULE_17 - shared sources or-ed
  // the vector cannot tell them apart, software reads the peripheral flags
  assign rawReq[`EVP_VEC_RESET] = resetPend;
  // system slots below the nmi never request
  assign rawReq[`EVP_RSV_A_HI:`EVP_RSV_A_LO] = `EVP_RSV_A_ZERO;
  assign rawReq[`EVP_VEC_NMI] = pinPend[`EVP_PIN_NMI];
  assign rawReq[`EVP_VEC_TRAP0 +: `EVP_TRAP_COUNT] = trapPend;
  assign rawReq[`EVP_VEC_BREAK] = breakPend;
  // the direct transition waits in its latch until enabled
  assign rawReq[`EVP_VEC_SLEEP] = sleepPend && sleepDirectEnable;
  // edge requests: each latch is gated by its own enable bit
  assign rawReq[`EVP_VEC_PIN0] = (pinPend[`EVP_PIN_EDGE_PIN_REQUEST_0] && pinEnable[`EVP_PIN_EDGE_PIN_REQUEST_0]) || lowVoltShared;
  assign rawReq[`EVP_VEC_PIN1 +: `EVP_PIN_UPPER] = pinPend[`EVP_PIN_EDGE_PIN_REQUEST_1 +: `EVP_PIN_UPPER] &
    pinEnable[`EVP_PIN_EDGE_PIN_REQUEST_1 +: `EVP_PIN_UPPER];
  // any of the six wake latches raises the one shared vector
  assign rawReq[`EVP_VEC_WAKE] = |(pinPend[`EVP_PIN_WAKE0 +: `EVP_WAKE_COUNT] &
    pinEnable[`EVP_PIN_WAKE0 +: `EVP_WAKE_COUNT]);
  assign rawReq[`EVP_VEC_CLKOVF] = clockOverflowReq;
  // reserved gap above the clock overflow
  assign rawReq[`EVP_RSV_B_HI:`EVP_RSV_B_LO] = `EVP_RSV_B_ZERO;
  // RULE_11 - 8-bit timer combined
  assign rawReq[`EVP_VEC_TMR8] = |timer8Req;
  // RULE_12 - serial units combined
  assign rawReq[`EVP_VEC_SER1] = |serialPrimaryReq;
  // RULE_13 - two-wire combined
  assign rawReq[`EVP_VEC_TWI] = |twoWireReq;
  // RULE_14 - timers and adc
  assign rawReq[`EVP_VEC_ADC] = adcEndReq;
  assign rawReq[`EVP_VEC_MT0] = |multiTimer0Req;
  assign rawReq[`EVP_VEC_MT1] = |multiTimer1Req;
  // reserved slot between the timer channels and the plain timer
  assign rawReq[`EVP_RSV_C] = `EVP_ZERO_BIT;
  assign rawReq[`EVP_VEC_PTMR] = plainTimerOvfReq;
  // reserved pair just below the second serial unit
  assign rawReq[`EVP_RSV_D_HI:`EVP_RSV_D_LO] = `EVP_RSV_D_ZERO;
  // RULE_12 - second serial unit
  assign rawReq[`EVP_VEC_SER2] = |serialSecondReq;

  // RULE_05 - mask bit hold-off
  // masked requests stay pending in their sources, only their entry waits
  // reset, nmi, traps and break pass whatever the mask bit says
  assign liveReq = rawReq & (maskBit ? `EVP_UNMASKED : ~`EVP_NONE_REQ);

  evp_prio_pick pick (
    .reqVec(liveReq),
    .anyReq(anyReq),
    .winVec(winVec)
  );

  // RULE_06 - entry at boundaries only
  // a new entry waits for the previous exception processing to finish,
  // except the reset vector, which starts straight after release
  // instrDone during entry processing is ignored, so a handler's first
  // instruction cannot be cut short by a fresh entry
  assign boundary = excDone || (instrDone && !excInService);
  assign takeNow = !coreReset && anyReq && (boundary || (winVec == `EVP_VEC_RESET));

  // RULE_08 - vector address twice number
  // the request strobe is one cycle; vector and address hold until the next entry
  // excInService marks entry processing from the strobe until excDone
  always @(posedge clk) begin
    if (srst) begin
      excReq <= `EVP_ZERO_BIT;
      excVector <= `EVP_VEC_RESET;
      excAddr <= {`EVP_ADDR_PAD, `EVP_VEC_RESET, `EVP_ADDR_LSB};
      excInService <= `EVP_ZERO_BIT;
    end else begin
      excReq <= takeNow;
      if (takeNow) begin
        excVector <= winVec;
        excAddr <= {`EVP_ADDR_PAD, winVec, `EVP_ADDR_LSB};
      end
      if (takeNow) begin
        excInService <= `EVP_ONE_BIT;
      end else if (excDone || coreReset) begin
        excInService <= `EVP_ZERO_BIT;
      end
    end
  end

endmodule

// ===== core/evp_regs.vh
// constants for the exception entry block: vector numbers, widths, masks
// assumes plain verilog-2005 and inclusion by bare name
`ifndef EVP_REGS_VH
`define EVP_REGS_VH

// vector numbers, lowest number wins
`define EVP_VEC_RESET 6'h00
`define EVP_VEC_NMI 6'h07
`define EVP_VEC_TRAP0 8
`define EVP_VEC_BREAK 12
`define EVP_VEC_SLEEP 13
`define EVP_VEC_PIN0 14
`define EVP_VEC_PIN1 15
`define EVP_VEC_WAKE 18
`define EVP_VEC_CLKOVF 19
`define EVP_VEC_TMR8 22
`define EVP_VEC_SER1 23
`define EVP_VEC_TWI 24
`define EVP_VEC_ADC 25
`define EVP_VEC_MT0 26
`define EVP_VEC_MT1 27
`define EVP_VEC_PTMR 29
`define EVP_VEC_SER2 32

// widths and counts
`define EVP_VEC_COUNT 33
`define EVP_VEC_W 6
`define EVP_ADDR_W 16
`define EVP_ADDR_PAD 9'h000
`define EVP_ADDR_LSB 1'b0
`define EVP_PIN_COUNT 11
`define EVP_PIN_NMI 0
`define EVP_PIN_EDGE_PIN_REQUEST_0 1
`define EVP_PIN_WAKE0 5
`define EVP_TRAP_COUNT 4
`define EVP_PIN_EDGE_PIN_REQUEST_1 2
`define EVP_PIN_UPPER 3
`define EVP_WAKE_COUNT 6

// reserved vector slots, tied off
`define EVP_RSV_A_LO 1
`define EVP_RSV_A_HI 6
`define EVP_RSV_A_ZERO 6'h00
`define EVP_RSV_B_LO 20
`define EVP_RSV_B_HI 21
`define EVP_RSV_B_ZERO 2'h0
`define EVP_RSV_C 28
`define EVP_RSV_D_LO 30
`define EVP_RSV_D_HI 31
`define EVP_RSV_D_ZERO 2'h0

// vectors that the cpu mask bit never holds off: 0, 7 and 8..12
`define EVP_UNMASKED 33'h000001F81
`define EVP_NONE_REQ 33'h000000000

// pin edge select and idle levels
`define EVP_EDGE_RISE 1'b1
`define EVP_PIN_IDLE 1'b1
`define EVP_ONE_BIT 1'b1
`define EVP_ZERO_BIT 1'b0

`endif

// ===== core/evp_pin_sync.v
// one external pin: three-stage synchroniser, agreement filter, edge pick
// assumes the pin is asynchronous to clk and the edge select is static enough
`timescale 1ns/10ps
`include "evp_regs.vh"

module evp_pin_sync (
  // clock and reset
  input wire clk,
  input wire srst,
  // pin and selection
  input wire pinRaw,
  input wire edgeSel,
  // filtered level and chosen-edge pulse
  output reg pinLevel,
  output reg pinEdge
);

  reg syncA;
  reg syncB;
  reg syncC;
  wire agree;
  wire changed;

  // syncA is read by syncB alone
  always @(posedge clk) begin
    if (srst) begin
      syncA <= `EVP_PIN_IDLE;
      syncB <= `EVP_PIN_IDLE;
      syncC <= `EVP_PIN_IDLE;
    end else begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // a change counts only once the last two stages agree
  assign agree = (syncB == syncC);
  assign changed = agree && (syncC != pinLevel);

  // RULE_15 - edge select decode
  always @(posedge clk) begin
    if (srst) begin
      pinLevel <= `EVP_PIN_IDLE;
      pinEdge <= `EVP_ZERO_BIT;
    end else begin
      pinEdge <= changed && ((syncC == `EVP_ONE_BIT) == (edgeSel == `EVP_EDGE_RISE));
      if (changed) begin
        pinLevel <= syncC;
      end
    end
  end

endmodule

// ===== core/evp_prio_pick.v
// fixed-priority pick over all vector requests, lowest vector number first
// assumes requests are already masked and enabled; purely combinational
`timescale 1ns/10ps
`include "evp_regs.vh"

module evp_prio_pick (
  // request per vector number
  input wire [`EVP_VEC_COUNT-1:0] reqVec,
  // winner
  output reg anyReq,
  output reg [`EVP_VEC_W-1:0] winVec
);

  integer i;

  // RULE_07 - lowest number wins
  // scanning downward lets the lowest set bit overwrite all others
  always @* begin
    anyReq = `EVP_ZERO_BIT;
    winVec = `EVP_VEC_RESET;
    for (i = `EVP_VEC_COUNT - 1; i >= 0; i = i - 1) begin
      if (reqVec[i]) begin
        anyReq = `EVP_ONE_BIT;
        winVec = i[`EVP_VEC_W-1:0];
      end
    end
  end

endmodule

// ===== verif/evp_core_props.sv
// concurrent checks on the exception entry block, seen only at its ports
// assumes one clock and the synchronous active-high srst of evp_core
`timescale 1ns/10ps

module evp_core_props (
  // clock and reset
  input wire clk,
  input wire srst,
  // chip clear pin, active low
  input wire chipClearPinN,
  // cpu side
  input wire watchdogOverflow,
  input wire instrDone,
  input wire excDone,
  input wire programState,
  input wire maskBit,
  input wire softwareVectorCall,
  input wire [1:0] softwareVectorField,
  // entry outputs
  input wire coreReset,
  input wire excReq,
  input wire [5:0] excVector,
  input wire [15:0] excAddr,
  input wire excInService
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // trap number captured at the call, since the field may change before entry
  logic [1:0] trapField;
  always @(posedge clk) begin
    if (srst) begin
      trapField <= 2'h0;
    end else if (softwareVectorCall) begin
      trapField <= softwareVectorField;
    end
  end

  property p_trap;
    (softwareVectorCall && programState && !excInService && !coreReset)
      |-> ##[1:8] (excReq && excVector == {4'h2, trapField});
  endproperty

  chk_release_vec0: assert property ($fell(srst) |-> ##[1:3] (excReq && excVector == 6'h00))
    else $error("no vector 0 entry after reset release");
  chk_pin_hold: assert property ((!chipClearPinN) [*6] |-> coreReset)
    else $error("chip clear pin low without holding the core");
  chk_wdog_entry: assert property (watchdogOverflow && !coreReset |=> coreReset ##[1:3] (excReq && excVector == 6'h00))
    else $error("watchdog overflow did not reset and enter vector 0");
  chk_trap_vec: assert property (p_trap)
    else $error("trap did not enter its vector");
  chk_mask_holds: assert property (excReq && $past(maskBit) |-> excVector == 6'h00 || excVector inside {[6'h07:6'h0C]})
    else $error("masked source entered");
  chk_boundary_only: assert property (excReq && excVector != 6'h00 |-> $past(excDone) || ($past(instrDone) && !$past(excInService)))
    else $error("entry outside a boundary");
  chk_service_span: assert property (excDone |=> excInService == excReq)
    else $error("service flag wrong after completion");
  chk_req_pulse: assert property (excReq && !excDone |-> excInService ##1 !excReq)
    else $error("entry request not a single pulse");
  chk_no_reserved: assert property (excReq |-> excVector <= 6'h20 && !(excVector inside {[6'h01:6'h06], 6'h14, 6'h15, 6'h1C, 6'h1E, 6'h1F}))
    else $error("reserved vector entered");
  chk_addr_twice: assert property (excReq |-> excAddr == {9'h000, excVector, 1'h0})
    else $error("vector address not twice the number");

  cov_nmi: cover property (excReq && excVector == 6'h07);
  cov_masked_break: cover property (maskBit && excReq && excVector == 6'h0C);
  cov_wdog: cover property (watchdogOverflow ##1 coreReset);
endmodule

bind evp_core evp_core_props chk_u (
  .clk(clk), .srst(srst), .chipClearPinN(chipClearPinN), .watchdogOverflow(watchdogOverflow),
  .instrDone(instrDone), .excDone(excDone),
  .programState(programState), .maskBit(maskBit), .softwareVectorCall(softwareVectorCall),
  .softwareVectorField(softwareVectorField), .coreReset(coreReset), .excReq(excReq), .excVector(excVector),
  .excAddr(excAddr), .excInService(excInService)
);

// ===== verif/evp_cpu_model.sv
// cpu sequencer model: instruction boundaries and exception processing time
// assumes excReq is a one-cycle pulse; excLen sets prompt or slow processing
`timescale 1ns/10ps

module evp_cpu_model (
  // clock and reset
  input wire clk,
  input wire srst,
  // entry block and bench
  input wire coreReset,
  input wire excReq,
  input wire [3:0] excLen,
  // completion pulses
  output logic instrDone,
  output logic excDone
);
  logic busy;
  logic [3:0] cnt;

  // boundaries at completion only
  // no instruction completes while entry processing runs, so none is cut short
  always @(posedge clk) begin
    instrDone <= 1'h0;
    excDone <= 1'h0;
    if (srst || coreReset) begin
      busy <= 1'h0;
      cnt <= 4'h0;
    end else if (excReq) begin
      busy <= 1'h1;
      cnt <= 4'h1;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt >= excLen) begin
        busy <= 1'h0;
        excDone <= 1'h1;
        cnt <= 4'h0;
      end
    end else begin
      cnt <= (cnt == 4'h2) ? 4'h0 : cnt + 4'h1;
      instrDone <= (cnt == 4'h2);
    end
  end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the exception entry block with a cpu sequencer model
// assumes evp_core, its checker and the model are compiled before this file
`timescale 1ns/10ps

module tb_top;
  logic clk, srst, programState, maskBit, sleepDirectEnable, wakeEnable, clearN;
  logic [1:0] softwareVectorField;
  logic [10:0] pinRaw, pinEdgeSel;
  logic [3:0] edgePinEnable, pulses, excLen;
  logic [31:0] per;
  logic [38:0] rows [0:12];
  wire instrDone, excDone, coreReset, excReq, excInService;
  wire [5:0] excVector;
  wire [15:0] excAddr;
  int num_errors = 0;
  int compares = 0;

  // low-voltage present so its share of vector 14 can be reached
  evp_core #(.LOW_VOLT_PRESENT(1)) dut_u (
    .clk(clk), .srst(srst), .chipClearPinN(clearN), .watchdogOverflow(pulses[3]), .instrDone(instrDone),
    .excDone(excDone), .programState(programState), .maskBit(maskBit), .softwareVectorCall(pulses[2]),
    .softwareVectorField(softwareVectorField), .addrBreakHit(pulses[1]), .sleepDirect(pulses[0]),
    .sleepDirectEnable(sleepDirectEnable), .pinRaw(pinRaw), .pinEdgeSel(pinEdgeSel), .edgePinEnable(edgePinEnable),
    .wakeEnable(wakeEnable), .lowVoltReq(per[0]), .clockOverflowReq(per[1]), .timer8Req(per[4:2]),
    .serialPrimaryReq(per[8:5]), .twoWireReq(per[14:9]), .adcEndReq(per[15]), .multiTimer0Req(per[20:16]),
    .multiTimer1Req(per[26:21]), .plainTimerOvfReq(per[27]), .serialSecondReq(per[31:28]),
    .coreReset(coreReset), .excReq(excReq), .excVector(excVector), .excAddr(excAddr), .excInService(excInService));
  evp_cpu_model cpu_u (.clk(clk), .srst(srst), .coreReset(coreReset), .excReq(excReq), .excLen(excLen),
    .instrDone(instrDone), .excDone(excDone));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task check(input string name, input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, want, seen);
    end
  endtask

  // one-cycle pulse on watchdog, trap, break and sleep inputs
  task fire(input logic [3:0] p);
    @(posedge clk);
    #1;
    pulses = p;
    @(posedge clk);
    #1;
    pulses = 4'h0;
  endtask

  // bounded wait for one entry (6'h3F: none expected), then for the handler to finish
  task expect_entry(input logic [5:0] v);
    logic hit;
    int i;
    hit = 1'h0;
    for (i = 0; i < 40 && !hit; i++) begin
      @(posedge clk);
      #1;
      if (excReq === 1'h1) begin
        hit = 1'h1;
        check("vector", excVector, v);
        check("address", excAddr, {9'h000, v, 1'h0});
        per = 32'h0;
      end
    end
    check("entry", hit, v != 6'h3F);
    for (i = 0; i < 40 && excInService !== 1'h0; i++) begin
      @(posedge clk);
      #1;
    end
    check("service", excInService, 1'h0);
  endtask

  task results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // the sequence needs under 1500 cycles; four times that is taken as a hang
  initial begin
    #24000;
    num_errors++;
    results();
  end

  initial begin
    rows = '{{32'h00000001, 1'h0, 6'h0E}, {32'h00000002, 1'h0, 6'h13}, {32'h00000010, 1'h0, 6'h16},
      {32'h00000004, 1'h0, 6'h16}, {32'h00000100, 1'h0, 6'h17}, {32'h00004000, 1'h0, 6'h18},
      {32'h00008000, 1'h0, 6'h19}, {32'h00100000, 1'h0, 6'h1A}, {32'h04000000, 1'h0, 6'h1B},
      {32'h08000000, 1'h0, 6'h1D}, {32'h80000000, 1'h0, 6'h20}, {32'h80000004, 1'h0, 6'h16},
      {32'h00008000, 1'h1, 6'h3F}};
    srst = 1'h1;
    clearN = 1'h1;
    programState = 1'h1;
    maskBit = 1'h0;
    sleepDirectEnable = 1'h0;
    wakeEnable = 1'h0;
    softwareVectorField = 2'h0;
    pinRaw = 11'h7FF;
    pinEdgeSel = 11'h000;
    edgePinEnable = 4'h0;
    pulses = 4'h0;
    excLen = 4'h4;
    per = 32'h0;
    repeat (12) @(posedge clk);
    #1;
    check("core reset", coreReset, 1'h1);
    srst = 1'h0;
    expect_entry(6'h00);
    // peripheral sources, shared and competing, prompt and slow cpu
    for (int r = 0; r < 13; r++) begin
      per = rows[r][38:7];
      maskBit = rows[r][6];
      excLen = r[0] ? 4'h1 : 4'h8;
      expect_entry(rows[r][5:0]);
    end
    maskBit = 1'h0;
    expect_entry(6'h19);
    maskBit = 1'h1;
    for (int f = 0; f < 4; f++) begin
      softwareVectorField = f[1:0];
      fire(4'h4);
      expect_entry(6'h08 + f[5:0]);
    end
    programState = 1'h0;
    fire(4'h4);
    expect_entry(6'h3F);
    programState = 1'h1;
    fire(4'h2);
    expect_entry(6'h0C);
    maskBit = 1'h0;
    sleepDirectEnable = 1'h1;
    fire(4'h1);
    expect_entry(6'h0D);
    maskBit = 1'h1;
    pinRaw[0] = 1'h0;
    expect_entry(6'h07);
    pinRaw[0] = 1'h1;
    maskBit = 1'h0;
    pinEdgeSel[2] = 1'h1;
    edgePinEnable = 4'h2;
    pinRaw[2] = 1'h0;
    expect_entry(6'h3F);
    pinRaw[2] = 1'h1;
    expect_entry(6'h0F);
    wakeEnable = 1'h1;
    pinRaw[10] = 1'h0;
    expect_entry(6'h12);
    fire(4'h8);
    check("core reset", coreReset, 1'h1);
    expect_entry(6'h00);
    // chip clear pin holds the core, vector 0 after its release
    clearN = 1'h0;
    repeat (8) @(posedge clk);
    #1;
    check("core reset", coreReset, 1'h1);
    check("request", excReq, 1'h0);
    clearN = 1'h1;
    expect_entry(6'h00);
    results();
  end
endmodule
